// ===== src/sync_sram_fifo_port.sv
// Two synchronous memory ports of equal width DW for burst SRAM and FIFOs.
// Assumes interface clocks arrive as pins and are sampled by clk.
`include "sync_port_consts.svh"

module sync_sram_fifo_port
   import sync_port_pkg::*;
#(
   parameter int NSPACE = 4,
   parameter int DW = 32,
   parameter int AW = 20
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [`REG_ADDR_W-1:0] regAddr,
   input wire logic [`REG_DATA_W-1:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   output logic [`REG_DATA_W-1:0] regRdata,
   input wire logic iface_clock_out_one,
   input wire logic iface_clock_out_two,
   input wire logic [`NUM_PORTS-1:0] reqValid,
   input wire logic [`NUM_PORTS-1:0] reqWrite,
   input wire logic [`NUM_PORTS-1:0][1:0] reqSpace,
   input wire logic [`NUM_PORTS-1:0][AW-1:0] reqAddr,
   input wire logic [`NUM_PORTS-1:0][3:0] reqLen,
   input wire logic [`NUM_PORTS-1:0][DW-1:0] reqWdata,
   output logic [`NUM_PORTS-1:0] reqReady,
   output logic [`NUM_PORTS-1:0] wdataTaken,
   output logic [`NUM_PORTS-1:0] rdValid,
   output logic [`NUM_PORTS-1:0][DW-1:0] rdData,
   output logic [`NUM_PORTS-1:0] accessDone,
   output logic [`NUM_PORTS-1:0][NSPACE-1:0] space_chip_enable_n,
   output logic [`NUM_PORTS-1:0] sync_address_strobe_n,
   output logic [`NUM_PORTS-1:0] sync_output_enable_n,
   output logic [`NUM_PORTS-1:0] sync_write_enable_n,
   output logic [`NUM_PORTS-1:0][AW-1:0] memAddr,
   output logic [`NUM_PORTS-1:0][DW-1:0] memDataOut,
   output logic [`NUM_PORTS-1:0] memDataOe,
   input wire logic [`NUM_PORTS-1:0][DW-1:0] memDataIn
);
   localparam int NREG = 2 * NSPACE;

   logic [NREG-1:0][`SEC_W-1:0] secReg;
   logic [NREG-1:0][`SEC_W-1:0] secNext;
   logic [`REG_DATA_W-1:0] rdataReg;
   logic [`REG_DATA_W-1:0] rdataNext;
   logic clkRiseOne;
   logic clkRiseTwo;
   logic [`NUM_PORTS-1:0] busy;

   // Each interface clock is found by its own synchroniser and edge pulse.
   pin_sync #(.W(1)) syncOne (
      .clk(clk),
      .sys_rst(sys_rst),
      .pinIn(iface_clock_out_one),
      .level(),
      .rise(clkRiseOne)
   );

   pin_sync #(.W(1)) syncTwo (
      .clk(clk),
      .sys_rst(sys_rst),
      .pinIn(iface_clock_out_two),
      .level(),
      .rise(clkRiseTwo)
   );

   // Registers 0..NSPACE-1 belong to port 0, the next NSPACE to port 1.
   always_comb begin
      secNext = secReg;
      rdataNext = '0;
      if (regWr && regAddr < 8'(NREG)) begin
         secNext[regAddr[$clog2(NREG)-1:0]] = regWdata[`SEC_W-1:0];
      end
      if (regRd) begin
         if (regAddr < 8'(NREG)) begin
            rdataNext[`SEC_W-1:0] = secReg[regAddr[$clog2(NREG)-1:0]];
         end else if (regAddr == `STATUS_IDX) begin
            rdataNext[`NUM_PORTS-1:0] = busy;
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         secReg <= {NREG{`SEC_RESET}};
         rdataReg <= '0;
      end else begin
         secReg <= secNext;
         rdataReg <= rdataNext;
      end
   end

   assign regRdata = rdataReg;

   for (genvar p = 0; p < `NUM_PORTS; p++) begin : gPort
      port_state_t stReg, stNext;
      logic [`SEC_W-1:0] reqCfg;
      logic [`SEC_W-1:0] curReg, curNext;
      logic [1:0] spaceReg, spaceNext;
      logic isWrReg, isWrNext;
      logic [4:0] beatsReg, beatsNext;
      logic [AW-1:0] addrReg, addrNext;
      logic [1:0] drainReg, drainNext;
      logic [3:0] capPipeReg, capPipeNext;
      logic [3:0] wrEnPipeReg, wrEnPipeNext;
      logic [3:0][DW-1:0] wrDataPipeReg, wrDataPipeNext;
      logic rdCmdReg, rdCmdNext;
      logic readyReg, readyNext;
      logic takenReg, takenNext;
      logic validReg, validNext;
      logic [DW-1:0] dataReg, dataNext;
      logic doneReg, doneNext;
      logic [NSPACE-1:0] ceNReg, ceNNext;
      logic strobeNReg, strobeNNext;
      logic oeNReg, oeNNext;
      logic weNReg, weNNext;
      logic [AW-1:0] outAddrReg, outAddrNext;
      logic [DW-1:0] outDataReg, outDataNext;
      logic outOeReg, outOeNext;
      logic [DW-1:0] dataSync;
      logic tick;
      logic capNow;
      latency_t rl, wl;
      logic ext, ren;

      pin_sync #(.W(DW)) syncData (
         .clk(clk),
         .sys_rst(sys_rst),
         .pinIn(memDataIn[p]),
         .level(dataSync),
         .rise()
      );

      assign reqCfg = secReg[p * NSPACE + int'(reqSpace[p])];
      assign rl = curReg[`FLD_RL_LSB +: 2];
      assign wl = curReg[`FLD_WL_LSB +: 2];
      assign ext = curReg[`FLD_EXT_BIT];
      assign ren = curReg[`FLD_REN_BIT];
      assign tick = curReg[`FLD_SEL_BIT] ? clkRiseTwo : clkRiseOne;
      // A read beat on the pins is sampled by the port at this edge.
      assign capNow = (rl == 2'd0) ? rdCmdReg : capPipeReg[rl - 2'd1];
      assign busy[p] = (stReg != ST_IDLE);

      always_comb begin
         stNext = stReg;
         curNext = curReg;
         spaceNext = spaceReg;
         isWrNext = isWrReg;
         beatsNext = beatsReg;
         addrNext = addrReg;
         drainNext = drainReg;
         capPipeNext = capPipeReg;
         wrEnPipeNext = wrEnPipeReg;
         wrDataPipeNext = wrDataPipeReg;
         rdCmdNext = rdCmdReg;
         readyNext = readyReg;
         takenNext = 1'b0;
         validNext = 1'b0;
         dataNext = dataReg;
         doneNext = 1'b0;
         ceNNext = ceNReg;
         strobeNNext = strobeNReg;
         oeNNext = oeNReg;
         weNNext = weNReg;
         outAddrNext = outAddrReg;
         outDataNext = outDataReg;
         outOeNext = outOeReg;
         if (stReg == ST_IDLE && reqValid[p] && readyReg) begin
            curNext = reqCfg;
            spaceNext = reqSpace[p];
            isWrNext = reqWrite[p];
            beatsNext = {1'b0, reqLen[p]} + 5'h01;
            addrNext = reqAddr[p];
            // Stale pipe bits of the last access would fire a false beat.
            capPipeNext = 4'h0;
            wrEnPipeNext = 4'h0;
            rdCmdNext = 1'b0;
            readyNext = 1'b0;
            stNext = ST_CMD;
         end else if (tick) begin
            // Idle ticks still run, so a deselect strobe lasts one tick.
            capPipeNext = {capPipeReg[2:0], rdCmdReg};
            wrEnPipeNext = {wrEnPipeReg[2:0], 1'b0};
            wrDataPipeNext = {wrDataPipeReg[2:0], reqWdata[p]};
            rdCmdNext = 1'b0;
            if (capNow) begin
               validNext = 1'b1;
               dataNext = dataSync;
            end
            strobeNNext = 1'b1;
            weNNext = 1'b1;
            outOeNext = 1'b0;
            if (wl != 2'd0 && wrEnPipeReg[wl - 2'd1]) begin
               outOeNext = 1'b1;
               outDataNext = wrDataPipeReg[wl - 2'd1];
            end
            case (stReg)
               ST_CMD: begin
                  ceNNext = '1;
                  ceNNext[spaceNext] = 1'b0;
                  // As a FIFO read enable the strobe marks reads only.
                  strobeNNext = ren & isWrReg;
                  oeNNext = isWrReg;
                  weNNext = ~isWrReg;
                  rdCmdNext = ~isWrReg;
                  outAddrNext = addrReg;
                  addrNext = addrReg + AW'(1);
                  beatsNext = beatsReg - 5'h01;
                  if (isWrReg) begin
                     takenNext = 1'b1;
                     wrEnPipeNext[0] = 1'b1;
                     if (wl == 2'd0) begin
                        outOeNext = 1'b1;
                        outDataNext = reqWdata[p];
                     end
                  end
                  if (beatsReg == 5'h01) begin
                     drainNext = isWrReg ? wl : rl;
                     stNext = ST_TAIL;
                  end
               end
               ST_TAIL: begin
                  // Chip enable follows output enable only when extended.
                  if (!ext || isWrReg) begin
                     ceNNext = '1;
                  end
                  if (drainReg == 2'd0) begin
                     oeNNext = 1'b1;
                     ceNNext = '1;
                     doneNext = 1'b1;
                     stNext = ren ? ST_IDLE : ST_DESEL;
                     readyNext = ren;
                  end else begin
                     drainNext = drainReg - 2'd1;
                  end
               end
               ST_IDLE: begin
                  readyNext = 1'b1;
               end
               ST_DESEL: begin
                  // Strobe with every chip enable high deselects the SRAM.
                  strobeNNext = 1'b0;
                  ceNNext = '1;
                  stNext = ST_IDLE;
                  readyNext = 1'b1;
               end
               default: begin
                  stNext = ST_IDLE;
                  readyNext = 1'b1;
               end
            endcase
         end
      end

      always_ff @(posedge clk or posedge sys_rst) begin
         if (sys_rst) begin
            stReg <= ST_IDLE;
            curReg <= `SEC_RESET;
            spaceReg <= 2'd0;
            isWrReg <= 1'b0;
            beatsReg <= 5'h00;
            addrReg <= '0;
            drainReg <= 2'd0;
            capPipeReg <= 4'h0;
            wrEnPipeReg <= 4'h0;
            wrDataPipeReg <= '0;
            rdCmdReg <= 1'b0;
            readyReg <= 1'b1;
            takenReg <= 1'b0;
            validReg <= 1'b0;
            dataReg <= '0;
            doneReg <= 1'b0;
            ceNReg <= '1;
            strobeNReg <= 1'b1;
            oeNReg <= 1'b1;
            weNReg <= 1'b1;
            outAddrReg <= '0;
            outDataReg <= '0;
            outOeReg <= 1'b0;
         end else begin
            stReg <= stNext;
            curReg <= curNext;
            spaceReg <= spaceNext;
            isWrReg <= isWrNext;
            beatsReg <= beatsNext;
            addrReg <= addrNext;
            drainReg <= drainNext;
            capPipeReg <= capPipeNext;
            wrEnPipeReg <= wrEnPipeNext;
            wrDataPipeReg <= wrDataPipeNext;
            rdCmdReg <= rdCmdNext;
            readyReg <= readyNext;
            takenReg <= takenNext;
            validReg <= validNext;
            dataReg <= dataNext;
            doneReg <= doneNext;
            ceNReg <= ceNNext;
            strobeNReg <= strobeNNext;
            oeNReg <= oeNNext;
            weNReg <= weNNext;
            outAddrReg <= outAddrNext;
            outDataReg <= outDataNext;
            outOeReg <= outOeNext;
         end
      end

      assign reqReady[p] = readyReg;
      assign wdataTaken[p] = takenReg;
      assign rdValid[p] = validReg;
      assign rdData[p] = dataReg;
      assign accessDone[p] = doneReg;
      assign space_chip_enable_n[p] = ceNReg;
      assign sync_address_strobe_n[p] = strobeNReg;
      assign sync_output_enable_n[p] = oeNReg;
      assign sync_write_enable_n[p] = weNReg;
      assign memAddr[p] = outAddrReg;
      assign memDataOut[p] = outDataReg;
      assign memDataOe[p] = outOeReg;
   end
endmodule

// ===== src/sync_port_consts.svh
// Constants for the synchronous memory port: offsets, fields, resets.
// Assumes a word-addressed register port, one register per aligned word.
`ifndef SYNC_PORT_CONSTS_SVH
`define SYNC_PORT_CONSTS_SVH

`define NUM_PORTS 2
`define REG_ADDR_W 8
`define REG_DATA_W 32
`define SEC_BASE_IDX 8'h00
`define STATUS_IDX 8'h08
`define FLD_RL_LSB 0
`define FLD_WL_LSB 2
`define FLD_EXT_BIT 4
`define FLD_REN_BIT 5
`define FLD_SEL_BIT 6
`define SEC_W 7
`define SEC_RESET 7'h00
`define LINK_PERIOD_NS 320
`define CLK_PERIOD_NS 40

`endif

// ===== src/sync_port_pkg.sv
// Types shared by the synchronous memory port.
// Assumes the constants header is compiled alongside.
package sync_port_pkg;
   typedef enum logic [1:0] {ST_IDLE, ST_CMD, ST_TAIL, ST_DESEL} port_state_t;
   typedef logic [1:0] latency_t;
endpackage

// ===== src/pin_sync.sv
// Two-flop synchroniser with a rising-edge pulse on bit 0.
// Assumes inputs come from outside the clk domain.
module pin_sync #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [W-1:0] pinIn,
   output logic [W-1:0] level,
   output logic rise
);
   logic [W-1:0] stage1Reg;
   logic [W-1:0] stage2Reg;
   logic lastReg;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1Reg <= '0;
         stage2Reg <= '0;
         lastReg <= 1'b0;
      end else begin
         stage1Reg <= pinIn;
         stage2Reg <= stage1Reg;
         lastReg <= stage2Reg[0];
      end
   end

   assign level = stage2Reg;
   assign rise = stage2Reg[0] & ~lastReg;
endmodule

// ===== verification/sram_model.sv
// Behavioural synchronous memory for one port: pipelined reads, write sink.
// Assumes lclk is the interface clock that the accessed space is timed to.
module sram_model #(
   parameter int DW = 32,
   parameter int AW = 20
) (
   input wire logic lclk,
   input wire logic [1:0] rdLat,
   input wire logic strobeN,
   input wire logic oeN,
   input wire logic selN,
   input wire logic [AW-1:0] addr,
   input wire logic [DW-1:0] dout,
   input wire logic dataOe,
   output logic [DW-1:0] din,
   output logic [DW-1:0] lastWr
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [3:0] pv = '0;
   logic [AW-1:0] pa [4];
   logic [DW-1:0] hold = '0;
   // Idle data lines toggle every clock, so a mistimed capture cannot pass.
   assign din = pv[rdLat] ? DW'(pa[rdLat]) ^ DW'(32'h5a5a_0000) : ~hold;
   always @(posedge lclk) begin
      pv <= {pv[2:0], !strobeN && !oeN && !selN};
      pa <= '{addr, pa[0], pa[1], pa[2]};
      hold <= din;
      if (dataOe)
         lastWr <= dout;
   end
endmodule

// ===== verification/sync_sram_fifo_port_chk.sv
// Assertions on the pins, handshakes and register bus of the port top.
// Assumes it is bound to the top and sees only its ports.
`include "sync_port_consts.svh"
module sync_sram_fifo_port_chk
   import sync_port_pkg::*;
#(
   parameter int NSPACE = 4,
   parameter int DW = 32,
   parameter int AW = 20
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic regRd,
   input wire logic [`REG_DATA_W-1:0] regRdata,
   input wire logic [`NUM_PORTS-1:0] reqValid,
   input wire logic [`NUM_PORTS-1:0] reqReady,
   input wire logic [`NUM_PORTS-1:0] rdValid,
   input wire logic [`NUM_PORTS-1:0] accessDone,
   input wire logic [`NUM_PORTS-1:0][NSPACE-1:0] space_chip_enable_n,
   input wire logic [`NUM_PORTS-1:0] sync_output_enable_n,
   input wire logic [`NUM_PORTS-1:0] sync_write_enable_n,
   input wire logic [`NUM_PORTS-1:0] memDataOe
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (sys_rst);
   property p_take;
      reqValid[0] && reqReady[0] |=> !reqReady[0];
   endproperty
   a_take: assert property (p_take) else $error("ready held");
   property p_rdPulse;
      rdValid[0] |=> !rdValid[0];
   endproperty
   a_rdPulse: assert property (p_rdPulse) else $error("long capture");
   property p_done;
      accessDone[0] |=> !accessDone[0] [*3];
   endproperty
   a_done: assert property (p_done) else $error("done repeated");
   property p_pins;
      sync_output_enable_n[0] || sync_write_enable_n[0];
   endproperty
   a_pins: assert property (p_pins) else $error("oe and we low");
   property p_oneCe;
      $countones(~space_chip_enable_n[0]) <= 1;
   endproperty
   a_oneCe: assert property (p_oneCe) else $error("two spaces on");
   property p_weCe;
      !sync_write_enable_n[0] |-> !(&space_chip_enable_n[0]);
   endproperty
   a_weCe: assert property (p_weCe) else $error("write unselected");
   property p_oeDrv;
      memDataOe[0] |-> sync_output_enable_n[0];
   endproperty
   a_oeDrv: assert property (p_oeDrv) else $error("bus clash");
   property p_reg;
      !regRd |=> regRdata == '0;
   endproperty
   a_reg: assert property (p_reg) else $error("stray read data");
   property p_oeHold;
      $fell(sync_output_enable_n[0]) |=> !sync_output_enable_n[0] [*4];
   endproperty
   a_oeHold: assert property (p_oeHold) else $error("short oe");
   c_rd: cover property (rdValid[0]);
   c_wr: cover property (memDataOe[0]);
   c_p1: cover property (accessDone[1]);
endmodule
bind sync_sram_fifo_port sync_sram_fifo_port_chk #(.NSPACE(NSPACE),
   .DW(DW), .AW(AW)) chk_u (.clk(clk), .sys_rst(sys_rst), .regRd(regRd),
   .regRdata(regRdata), .reqValid(reqValid), .reqReady(reqReady),
   .rdValid(rdValid), .accessDone(accessDone),
   .space_chip_enable_n(space_chip_enable_n),
   .sync_output_enable_n(sync_output_enable_n),
   .sync_write_enable_n(sync_write_enable_n), .memDataOe(memDataOe));

// ===== verification/tb_top.sv
// Bench: register map, then random reads and writes on both ports.
// Assumes one memory model per port, timed by the selected clock.
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int AW = 20;
   logic clk = 0, sys_rst = 1, linkOne = 0, linkTwo = 0;
   logic [7:0] regAddr = '0;
   logic [31:0] regWdata = '0, regRdata, v, cfg;
   logic regWr = 0, regRd = 0, desPrev = 0;
   logic [1:0] reqValid = '0, reqWrite = '0, sel = '0;
   logic [1:0][1:0] reqSpace = '0, rl = '0;
   logic [1:0][AW-1:0] reqAddr = '0, memAddr;
   logic [1:0][3:0] reqLen = '0, space_chip_enable_n;
   logic [1:0][31:0] reqWdata = '0, rdData, memDataOut;
   logic [1:0] reqReady, wdataTaken, rdValid, accessDone, memDataOe;
   logic [1:0] sync_address_strobe_n, sync_output_enable_n;
   logic [1:0] sync_write_enable_n;
   wire logic [1:0][31:0] memDataIn, lastWr;
   int badCount = 0, checks = 0, seed = 75, nRd, nDes, nOeNoCe, p;
   always #20 clk = ~clk;
   always #160 linkOne = ~linkOne;
   // Same rate as clock one, a quarter period early, edges off clk's rise.
   always begin
      #80;
      linkTwo = ~linkTwo;
      #80;
   end
   sync_sram_fifo_port #(.NSPACE(4), .DW(32), .AW(AW)) dut_u (.clk,
      .sys_rst, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
      .iface_clock_out_one(linkOne), .iface_clock_out_two(linkTwo),
      .reqValid, .reqWrite, .reqSpace, .reqAddr, .reqLen, .reqWdata,
      .reqReady, .wdataTaken, .rdValid, .rdData, .accessDone,
      .space_chip_enable_n, .sync_address_strobe_n, .sync_output_enable_n,
      .sync_write_enable_n, .memAddr, .memDataOut, .memDataOe, .memDataIn);
   for (genvar g = 0; g < 2; g++) begin : mdl
      sram_model #(.DW(32), .AW(AW)) m_u (.lclk(sel[g] ? linkTwo : linkOne),
         .rdLat(rl[g]), .strobeN(sync_address_strobe_n[g]),
         .oeN(sync_output_enable_n[g]), .selN(&space_chip_enable_n[g]),
         .addr(memAddr[g]), .dout(memDataOut[g]), .dataOe(memDataOe[g]),
         .din(memDataIn[g]), .lastWr(lastWr[g]));
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         badCount++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   function automatic logic [31:0] expData(input logic [AW-1:0] a);
      return {12'h000, a} ^ 32'h5a5a_0000;
   endfunction
   task automatic regW(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1;
      @(posedge clk);
      regWr <= 0;
   endtask
   task automatic regR(input logic [7:0] a, output logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1;
      @(posedge clk);
      regRd <= 0;
      @(negedge clk);
      d = regRdata;
   endtask
   task automatic access(input int pp, input logic wr, input logic [1:0] sp);
      int n;
      logic [31:0] wd;
      logic [3:0] len;
      wd = $random(seed);
      len = wr ? 4'h0 : 4'($random(seed) & 3);
      p = pp;
      nRd = 0;
      nDes = 0;
      nOeNoCe = 0;
      reqValid[pp] <= 1;
      reqWrite[pp] <= wr;
      reqSpace[pp] <= sp;
      reqAddr[pp] <= AW'($random(seed));
      reqLen[pp] <= len;
      reqWdata[pp] <= wd;
      @(posedge clk);
      reqValid[pp] <= 0;
      regR(8'h08, v);
      check(v, 32'(1) << pp);
      for (n = 0; n < 500 && reqReady[pp] !== 1'b1; n++) @(negedge clk);
      // Let the monitor finish the edge at which ready returned.
      @(negedge clk);
      check(n < 500, 1'b1);
      check(nRd, wr ? 1 : len + 1);
      if (wr) check(lastWr[pp], wd);
      check(nDes != 0, !cfg[5]);
      if (!wr && cfg[1:0] != 0) check(nOeNoCe == 0, cfg[4]);
   endtask
   task automatic print_verdict();
      $display("mismatches %0d comparisons %0d", badCount, checks);
      if (badCount == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   always @(negedge clk) begin
      if (rdValid[p]) check(rdData[p], expData(reqAddr[p] + AW'(nRd)));
      if (rdValid[p] || wdataTaken[p]) nRd++;
      // A deselect is counted once, when it starts.
      if (!sync_address_strobe_n[p] && &space_chip_enable_n[p] && !desPrev)
         nDes++;
      desPrev = !sync_address_strobe_n[p] && &space_chip_enable_n[p];
      if (!sync_output_enable_n[p] && &space_chip_enable_n[p]) nOeNoCe++;
   end
   initial begin
      #2_000_000;
      badCount++;
      print_verdict();
   end
   initial begin
      repeat (12) @(posedge clk);
      check({reqReady, sync_address_strobe_n, sync_output_enable_n,
         sync_write_enable_n, memDataOe}, 10'h3fc);
      sys_rst <= 0;
      // The write to an unmapped index must leave every read at zero.
      regW(8'h09, 32'hffff_ffff);
      for (int i = 0; i < 10; i++) begin
         regR(8'(i), v);
         check(v, 0);
      end
      for (int i = 0; i < 8; i++) begin
         cfg = $random(seed);
         regW(8'(i), cfg);
         regR(8'(i), v);
         check(v, cfg & 32'h0000_007f);
      end
      for (int i = 0; i < 128; i++) begin
         int pp;
         logic [1:0] sp;
         pp = $random(seed) & 1;
         sp = 2'($random(seed));
         cfg = {25'h000_0000, 1'($random(seed)), 6'(i >> 1)};
         regW(8'(pp * 4 + sp), cfg);
         rl[pp] <= cfg[1:0];
         sel[pp] <= cfg[6];
         access(pp, i[0], sp);
      end
      print_verdict();
   end
endmodule
